// ==== logic/scs_status_regs.sv ====
// Per-channel buffer, external and special receive status registers
// Assumes receiver and transmitter logic on core_clk; pins are asynchronous
//
// Design decisions made here: strobed register access and the placing of the registers.
`include "scs_consts.svh"

module scs_status_regs (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    srst,
    // Register port
    input  wire logic [2:0]              reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [7:0]              reg_rdata,
    // Modem and sync pins
    input  wire logic                    cts_pin_n,
    input  wire logic                    carrier_detect_pin_n,
    input  wire logic                    sync_pin_in_n,
    output logic                         sync_pin_out_n,
    output logic                         sync_pin_oe,
    input  wire logic                    rx_clk_pin,
    // Receiver events
    input  wire logic                    rx_push,
    input  wire scs_pkg::scs_rx_char_type rx_char,
    input  wire logic                    rx_enable,
    input  wire logic                    sync_pattern_det,
    input  wire logic                    char_sync_done,
    input  wire logic                    open_flag_det,
    input  wire scs_pkg::scs_frame_stat_type frame_fifo_exit,
    output logic                         start_bit_blank,
    // Transmitter and baud generator
    input  wire logic                    tx_load,
    input  wire logic                    tx_taken,
    input  wire logic                    crc_sending,
    input  wire logic                    all_sent,
    input  wire logic                    brg_zero,
    // Status to the interrupt logic
    output logic                         ext_status_pending,
    output logic                         special_rx_cond
);

    // Pin synchronisers
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic       rxc_d_r;
    // Control registers
    logic [7:0] ext_en_r;
    logic [7:0] mode_ctrl_r;
    scs_pkg::scs_mode_type mode;
    // Status state
    logic       hunt_r;
    logic       tx_empty_r;
    logic       zc_served_r;
    logic       pend_r;
    logic       ovr_latch_r;
    logic       par_latch_r;
    logic       special_r;
    logic [3:0] blank_cnt_r;
    logic       sync_out_n_r;
    // Receive FIFO
    scs_pkg::scs_rx_entry_type rx_mem [`SCS_RX_DEPTH];
    logic [`SCS_RX_PTR_W-1:0] wr_ptr_r;
    logic [`SCS_RX_PTR_W-1:0] rd_ptr_r;
    logic [`SCS_RX_PTR_W-1:0] cnt_r;
    // Decoded strobes and views
    logic       chan_rst;
    logic       cmd_wr;
    logic       enter_hunt;
    logic       clr_ext;
    logic       err_rst;
    logic       rx_pop;
    logic       rx_full;
    logic       is_async;
    logic       is_bisync;
    logic       is_sdlc;
    logic       fifo_view;
    logic       rxc_rise;
    logic       par_mismatch;
    logic [2:0] src_live;
    logic [2:0] src_en;
    logic [2:0] src_stat;
    logic [2:0] src_evt;
    logic       zc_bit;
    logic       zc_evt;
    logic       any_evt;
    logic [7:0] buf_ext_status;
    logic [7:0] special_rx_status;
    scs_pkg::scs_rx_entry_type head;

    // Two flip-flops on every pin input
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
        end else begin
            pin_s1_r <= {rx_clk_pin, ~sync_pin_in_n, ~carrier_detect_pin_n, ~cts_pin_n};
            pin_s2_r <= pin_s1_r;
        end
    end

    // Receive clock edge finder
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rxc_d_r <= 1'b0;
        end else begin
            rxc_d_r <= pin_s2_r[3];
        end
    end
    assign rxc_rise = pin_s2_r[3] && !rxc_d_r;

    // Register port decode
    assign cmd_wr     = reg_wr && (reg_addr == `SCS_OFF_COMMAND);
    assign chan_rst   = cmd_wr && reg_wdata[`SCS_CMD_CHANNEL_RESET];
    assign enter_hunt = cmd_wr && reg_wdata[`SCS_CMD_ENTER_HUNT];
    assign clr_ext    = cmd_wr && reg_wdata[`SCS_CMD_RESET_EXT];
    assign err_rst    = cmd_wr && reg_wdata[`SCS_CMD_ERROR_RESET];
    assign rx_pop     = reg_rd && (reg_addr == `SCS_OFF_RX_DATA) && (cnt_r != 2'h0);

    // Mode decode
    assign mode      = scs_pkg::scs_mode_type'(mode_ctrl_r[`SCS_MODE_MSB:`SCS_MODE_LSB]);
    assign is_async  = (mode == scs_pkg::SCS_MODE_ASYNC);
    assign is_bisync = (mode == scs_pkg::SCS_MODE_MONOSYNC) || (mode == scs_pkg::SCS_MODE_BISYNC);
    assign is_sdlc   = (mode == scs_pkg::SCS_MODE_SDLC);
    assign fifo_view = is_sdlc && ext_en_r[`SCS_EN_STAT_FIFO];

    // Enable and mode registers; channel reset restores defaults
    always_ff @(posedge core_clk) begin
        if (srst || chan_rst) begin
            ext_en_r    <= `SCS_EN_RESET;
            mode_ctrl_r <= `SCS_MC_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `SCS_OFF_EXT_ENABLE) begin
                ext_en_r <= reg_wdata;
            end
            if (reg_addr == `SCS_OFF_MODE_CTRL) begin
                mode_ctrl_r <= reg_wdata;
            end
        end
    end

    // Hunt state of the character synchroniser
    always_ff @(posedge core_clk) begin
        if (srst || chan_rst) begin
            hunt_r <= 1'b1;
        end else if (is_bisync) begin
            if (enter_hunt) begin
                hunt_r <= 1'b1;
            end else if (char_sync_done) begin
                hunt_r <= 1'b0;
            end
        end else if (is_sdlc) begin
            if (enter_hunt || !rx_enable) begin
                hunt_r <= 1'b1;
            end else if (open_flag_det) begin
                hunt_r <= 1'b0;
            end
        end else if (enter_hunt) begin
            hunt_r <= 1'b1;
        end
    end

    // Source levels: cts, sync/hunt, carrier
    always_comb begin
        src_live[0] = pin_s2_r[0];
        src_live[2] = pin_s2_r[1];
        src_en[0]   = ext_en_r[`SCS_EN_CTS];
        src_en[2]   = ext_en_r[`SCS_EN_CARRIER];
        src_en[1]   = ext_en_r[`SCS_EN_SYNC];
        if (is_async && mode_ctrl_r[`SCS_MC_CRYSTAL_OSCILLATOR_OPTION]) begin
            src_live[1] = 1'b0;
            src_en[1]   = 1'b0;
        end else if (is_async) begin
            src_live[1] = pin_s2_r[2];
        end else if (mode == scs_pkg::SCS_MODE_EXT_SYNC) begin
            src_live[1] = pin_s2_r[2];
        end else begin
            src_live[1] = hunt_r;
        end
    end

    // One latch per external source
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_src
            scs_ext_latch u_latch (
                .core_clk   (core_clk),
                .srst       (srst || chan_rst),
                .live_lvl   (src_live[gi]),
                .irq_en     (src_en[gi]),
                .pending    (pend_r),
                .status_bit (src_stat[gi]),
                .change_evt (src_evt[gi])
            );
        end
    endgenerate

    // Zero count: live bit, one interrupt per stay at zero
    assign zc_bit = ext_en_r[`SCS_EN_ZERO_COUNT] && brg_zero;
    assign zc_evt = zc_bit && !pend_r && !zc_served_r;
    always_ff @(posedge core_clk) begin
        if (srst || chan_rst) begin
            zc_served_r <= 1'b0;
        end else if (!brg_zero) begin
            zc_served_r <= 1'b0;
        end else if (zc_evt || !ext_en_r[`SCS_EN_ZERO_COUNT]) begin
            zc_served_r <= 1'b1;
        end
    end

    // External status pending: a new event wins over the clear
    assign any_evt = (|src_evt) || zc_evt;
    always_ff @(posedge core_clk) begin
        if (srst || chan_rst) begin
            pend_r <= 1'b0;
        end else if (any_evt) begin
            pend_r <= 1'b1;
        end else if (clr_ext) begin
            pend_r <= 1'b0;
        end
    end
    assign ext_status_pending = pend_r;

    // Transmit buffer empty flag
    always_ff @(posedge core_clk) begin
        if (srst || chan_rst) begin
            tx_empty_r <= 1'b1;
        end else if (tx_load) begin
            tx_empty_r <= 1'b0;
        end else if (tx_taken) begin
            tx_empty_r <= 1'b1;
        end
    end

    // Sync pin drives pulses only in character sync modes
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sync_out_n_r <= 1'b1;
        end else begin
            sync_out_n_r <= !(is_bisync && sync_pattern_det);
        end
    end
    assign sync_pin_out_n = sync_out_n_r;
    assign sync_pin_oe    = is_bisync;

    // Parity check against the programmed sense
    assign par_mismatch = mode_ctrl_r[`SCS_MC_PAR_EN]
                          && ((^{rx_char.data, rx_char.parity_bit}) != mode_ctrl_r[`SCS_MC_PAR_ODD]);
    assign rx_full = (cnt_r == `SCS_RX_DEPTH);
    assign head    = rx_mem[rd_ptr_r];

    // Receive FIFO storage; a push into a full FIFO overwrites the newest
    always_ff @(posedge core_clk) begin
        if (err_rst) begin
            rx_mem[rd_ptr_r].stat.crc_framing  <= 1'b0;
            rx_mem[rd_ptr_r].stat.end_of_frame <= 1'b0;
        end
        if (rx_push) begin
            rx_mem[rx_full ? ((wr_ptr_r == 2'h0) ? `SCS_RX_LAST : wr_ptr_r - 2'h1)
                           : wr_ptr_r] <= '{
                data: rx_char.data,
                stat: '{
                    end_of_frame: is_sdlc && rx_char.end_of_frame,
                    crc_framing:  rx_char.crc_framing,
                    overrun:      rx_full,
                    parity_err:   par_mismatch,
                    residue:      is_sdlc ? rx_char.residue : `SCS_RESIDUE_IDLE
                }
            };
        end
    end

    // FIFO pointers and fill count; system or channel reset empties it
    always_ff @(posedge core_clk) begin
        if (srst || chan_rst) begin
            wr_ptr_r <= 2'h0;
            rd_ptr_r <= 2'h0;
            cnt_r    <= 2'h0;
        end else begin
            if (rx_push && !rx_full) begin
                wr_ptr_r <= (wr_ptr_r == `SCS_RX_LAST) ? 2'h0 : wr_ptr_r + 2'h1;
            end
            if (rx_pop) begin
                rd_ptr_r <= (rd_ptr_r == `SCS_RX_LAST) ? 2'h0 : rd_ptr_r + 2'h1;
            end
            if (rx_push && !rx_full && !rx_pop) begin
                cnt_r <= cnt_r + 2'h1;
            end else if (rx_pop && !(rx_push && !rx_full)) begin
                cnt_r <= cnt_r - 2'h1;
            end
        end
    end

    // Latched receive errors held until error reset
    always_ff @(posedge core_clk) begin
        if (srst || chan_rst) begin
            ovr_latch_r <= 1'b0;
            par_latch_r <= 1'b0;
        end else begin
            if (rx_pop && head.stat.overrun) begin
                ovr_latch_r <= 1'b1;
            end else if (err_rst) begin
                ovr_latch_r <= 1'b0;
            end
            if (rx_push && par_mismatch) begin
                par_latch_r <= 1'b1;
            end else if (err_rst) begin
                par_latch_r <= 1'b0;
            end
        end
    end

    // Special receive condition level for the vector logic
    always_ff @(posedge core_clk) begin
        if (srst || chan_rst) begin
            special_r <= 1'b0;
        end else begin
            special_r <= ovr_latch_r || ((cnt_r != 2'h0) && head.stat.overrun)
                         || (mode_ctrl_r[`SCS_MC_PAR_SPECIAL] && par_latch_r)
                         || ((cnt_r != 2'h0) && head.stat.end_of_frame);
        end
    end
    assign special_rx_cond = special_r;

    // Half-bit start blanking after a framing error, counted on rx clock
    always_ff @(posedge core_clk) begin
        if (srst || chan_rst) begin
            blank_cnt_r <= 4'h0;
        end else if (rx_push && is_async && rx_char.crc_framing) begin
            blank_cnt_r <= `SCS_HALF_BIT_EDGES;
        end else if (rxc_rise && (blank_cnt_r != 4'h0)) begin
            blank_cnt_r <= blank_cnt_r - 4'h1;
        end
    end
    assign start_bit_blank = (blank_cnt_r != 4'h0);

    // Buffer and external status view
    always_comb begin
        buf_ext_status                      = 8'h00;
        buf_ext_status[`SCS_B0_CTS]         = src_stat[0];
        buf_ext_status[`SCS_B0_SYNC_HUNT]   = src_stat[1];
        buf_ext_status[`SCS_B0_CARRIER]     = src_stat[2];
        buf_ext_status[`SCS_B0_TX_EMPTY]    = tx_empty_r && !crc_sending;
        buf_ext_status[`SCS_B0_ZERO_COUNT]  = zc_bit;
        buf_ext_status[`SCS_B0_RX_AVAIL]    = (cnt_r != 2'h0);
    end

    // Special receive status view; FIFO exit values replace live status
    always_comb begin
        special_rx_status = {1'b0, 1'b0, 1'b0, 1'b0, `SCS_RESIDUE_IDLE, all_sent};
        if (cnt_r != 2'h0) begin
            special_rx_status[7]   = head.stat.end_of_frame && is_sdlc;
            special_rx_status[6]   = head.stat.crc_framing;
            special_rx_status[3:1] = is_sdlc ? head.stat.residue : `SCS_RESIDUE_IDLE;
        end
        special_rx_status[5] = ovr_latch_r || ((cnt_r != 2'h0) && head.stat.overrun);
        special_rx_status[4] = par_latch_r;
        if (fifo_view) begin
            special_rx_status[6]   = frame_fifo_exit.crc_err;
            special_rx_status[5]   = frame_fifo_exit.overrun;
            special_rx_status[3:1] = frame_fifo_exit.residue;
        end
    end

    // Read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge core_clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `SCS_OFF_BUF_EXT_STATUS: reg_rdata <= buf_ext_status;
                `SCS_OFF_SPECIAL_RX:     reg_rdata <= special_rx_status;
                `SCS_OFF_EXT_ENABLE:     reg_rdata <= ext_en_r;
                `SCS_OFF_MODE_CTRL:      reg_rdata <= mode_ctrl_r;
                `SCS_OFF_RX_DATA:        reg_rdata <= (cnt_r != 2'h0) ? head.data : 8'h00;
                `SCS_OFF_PENDING:        reg_rdata <= {6'h00, special_r, pend_r};
                default:                 reg_rdata <= 8'h00;
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_hunt_cmd;
        is_bisync && enter_hunt && !chan_rst;
    endsequence
    sequence s_hunt_done;
        is_bisync && char_sync_done && !enter_hunt && !chan_rst;
    endsequence

    AST_CTS_LIVE: assert property (!ext_en_r[`SCS_EN_CTS] |-> buf_ext_status[5] == pin_s2_r[0])
        else $error("cts bit not live while disabled");
    AST_CRYSTAL_OSCILLATOR_OPTION_SYNC: assert property (is_async && mode_ctrl_r[`SCS_MC_CRYSTAL_OSCILLATOR_OPTION]
                                   |-> !buf_ext_status[4] && !src_evt[1])
        else $error("sync bit not forced low");
    AST_HUNT_SET: assert property (s_hunt_cmd |=> hunt_r)
        else $error("enter hunt did not set hunt");
    AST_HUNT_CLR: assert property (s_hunt_done |=> !hunt_r)
        else $error("synchronisation did not clear hunt");
    AST_SYNC_PULSE: assert property (is_bisync && sync_pattern_det |=> !sync_pin_out_n)
        else $error("sync pattern gave no low pulse");
    AST_TXE_LOAD: assert property (tx_load && !chan_rst |=> !buf_ext_status[2])
        else $error("tx empty not cleared by load");
    AST_EOF_MODE: assert property (!is_sdlc |-> !special_rx_status[7])
        else $error("end of frame outside frame mode");
    AST_BLANK: assert property (rx_push && is_async && rx_char.crc_framing && !chan_rst
                                |=> start_bit_blank [*2])
        else $error("no start blank after framing error");
    AST_RESIDUE: assert property (is_async && !fifo_view |-> special_rx_status[3:1] == 3'h3)
        else $error("residue not idle in async");
    AST_PEND_HOLD: assert property (pend_r && !clr_ext && !chan_rst |=> pend_r)
        else $error("pending dropped without clear");

endmodule // scs_status_regs

// ==== common/scs_consts.svh ====
// Constants of the serial channel status register bank
// Assumes inclusion by bare name from design files; definitions only
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

// Register offsets (register index on the plain register port)
`define SCS_OFF_BUF_EXT_STATUS   3'h0
`define SCS_OFF_SPECIAL_RX       3'h1
`define SCS_OFF_EXT_ENABLE       3'h2
`define SCS_OFF_MODE_CTRL        3'h3
`define SCS_OFF_COMMAND          3'h4
`define SCS_OFF_RX_DATA          3'h5
`define SCS_OFF_PENDING          3'h6

// Buffer and external status bit positions
`define SCS_B0_CTS               5
`define SCS_B0_SYNC_HUNT         4
`define SCS_B0_CARRIER           3
`define SCS_B0_TX_EMPTY          2
`define SCS_B0_ZERO_COUNT        1
`define SCS_B0_RX_AVAIL          0

// External status enable bit positions and reset value
`define SCS_EN_CTS               5
`define SCS_EN_SYNC              4
`define SCS_EN_CARRIER           3
`define SCS_EN_STAT_FIFO         2
`define SCS_EN_ZERO_COUNT        1
`define SCS_EN_RESET             8'h38

// Mode control fields and reset value
`define SCS_MODE_LSB             0
`define SCS_MODE_MSB             2
`define SCS_MC_CRYSTAL_OSCILLATOR_OPTION              3
`define SCS_MC_PAR_EN            4
`define SCS_MC_PAR_ODD           5
`define SCS_MC_PAR_SPECIAL       6
`define SCS_MC_RESET             8'h00

// Command bits
`define SCS_CMD_ENTER_HUNT       0
`define SCS_CMD_RESET_EXT        1
`define SCS_CMD_ERROR_RESET      2
`define SCS_CMD_CHANNEL_RESET    3

// Pending register bits
`define SCS_PD_EXT               0
`define SCS_PD_SPECIAL           1

// Residue code after reset and outside frame mode
`define SCS_RESIDUE_IDLE         3'h3

// Receive FIFO depth and pointer width
`define SCS_RX_DEPTH             3
`define SCS_RX_PTR_W             2
`define SCS_RX_LAST              2'h2

// Receive clock edges in half a bit time (x16 sampling)
`define SCS_HALF_BIT_EDGES       4'h8

`endif

// ==== common/scs_pkg.sv ====
// Types of the serial channel status register bank
// Assumes no other package; constants live in scs_consts.svh
package scs_pkg;

    // Operating mode of the channel
    typedef enum logic [2:0] {
        SCS_MODE_ASYNC,
        SCS_MODE_MONOSYNC,
        SCS_MODE_BISYNC,
        SCS_MODE_SDLC,
        SCS_MODE_EXT_SYNC
    } scs_mode_type;

    // Status carried by each received character
    typedef struct packed {
        logic       end_of_frame;
        logic       crc_framing;
        logic       overrun;
        logic       parity_err;
        logic [2:0] residue;
    } scs_rx_status_type;

    // Received character as the receiver hands it over
    typedef struct packed {
        logic [7:0] data;
        logic       parity_bit;
        logic       end_of_frame;
        logic       crc_framing;
        logic [2:0] residue;
    } scs_rx_char_type;

    // Receive FIFO entry
    typedef struct packed {
        logic [7:0]        data;
        scs_rx_status_type stat;
    } scs_rx_entry_type;

    // Values at the exit location of the frame status FIFO
    typedef struct packed {
        logic       crc_err;
        logic       overrun;
        logic [2:0] residue;
    } scs_frame_stat_type;

endpackage : scs_pkg

// ==== logic/scs_ext_latch.sv ====
// One external status source: live or latched view and change events
// Assumes the level input is already in the core_clk domain
module scs_ext_latch (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic srst,
    // Source and control
    input  wire logic live_lvl,
    input  wire logic irq_en,
    input  wire logic pending,
    // Results
    output logic      status_bit,
    output logic      change_evt
);

    logic ref_r;

    // A change counts only while enabled and nothing is pending
    assign change_evt = irq_en && !pending && (live_lvl != ref_r);
    // Enabled shows the captured level, disabled the live one
    assign status_bit = irq_en ? ref_r : live_lvl;

    // Reference follows the source except while enabled and an interrupt is pending
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ref_r <= 1'b0;
        end else if (!irq_en || !pending) begin
            ref_r <= live_lvl;
        end
    end

endmodule // scs_ext_latch

// ==== tb/scs_far_end.sv ====
// Far-end model: modem pins, external sync logic and receive clock
// Assumes the bench commands levels; modem and sync pins are active low
module scs_far_end (
    // Commands from the bench
    input  wire logic cts_on,
    input  wire logic car_on,
    input  wire logic hunt,
    input  wire logic clk_run,
    // Pins toward the block
    output logic      cts_pin_n,
    output logic      carrier_detect_pin_n,
    output logic      sync_pin_in_n,
    output logic      rx_clk_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Modem pin levels
    assign cts_pin_n = ~cts_on;
    assign carrier_detect_pin_n = ~car_on;
    // Sync input held inactive while hunting
    assign sync_pin_in_n = hunt;
    // Receive clock stands still outside frames
    initial rx_clk_pin = 1'h0;
    always #40 rx_clk_pin = clk_run & ~rx_clk_pin;
endmodule // scs_far_end

// ==== tb/test_scs_status_regs.sv ====
// Self-checking bench for the status register bank
// Assumes scs_far_end and the design package are compiled first
module test_scs_status_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'h0, srst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, seed = 8'h18, q[3];
    logic rx_push = 1'h0, tx_load = 1'h0, tx_taken = 1'h0, crc_sending = 1'h0;
    logic brg_zero = 1'h0, all_sent = 1'h1, sync_pattern_det = 1'h0, char_sync_done = 1'h0;
    logic cts_on = 1'h0, car_on = 1'h0, clk_run = 1'h0;
    logic cts_pin_n, carrier_detect_pin_n, sync_pin_in_n, rx_clk_pin, sync_pin_out_n;
    logic sync_pin_oe, start_bit_blank, ext_status_pending, special_rx_cond;
    scs_pkg::scs_rx_char_type rx_char = '0;
    int failures = 0, n_compared = 0;
    // Clock
    always #5 core_clk = ~core_clk;
    scs_far_end far (.cts_on, .car_on, .hunt(1'h1), .clk_run, .cts_pin_n,
        .carrier_detect_pin_n, .sync_pin_in_n, .rx_clk_pin);
    scs_status_regs uut (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .cts_pin_n, .carrier_detect_pin_n, .sync_pin_in_n, .sync_pin_out_n,
        .sync_pin_oe, .rx_clk_pin, .rx_push, .rx_char, .rx_enable(1'h1), .sync_pattern_det,
        .char_sync_done, .open_flag_det(1'h0), .frame_fifo_exit('0), .start_bit_blank,
        .tx_load, .tx_taken, .crc_sending, .all_sent, .brg_zero, .ext_status_pending,
        .special_rx_cond);
    // Random source and expected status byte
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] st0(input logic c, input logic d, input logic t);
        return {2'h0, c, 1'h0, d, t, 2'h0};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic push(input logic [7:0] d, input logic pb, input logic fe);
        @(posedge core_clk);
        rx_push <= 1'h1;
        rx_char <= '{d, pb, 1'h0, fe, 3'h3};
        @(posedge core_clk);
        rx_push <= 1'h0;
    endtask
    task automatic end_of_test;
        if (failures == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog
    initial begin
        #100000;
        failures++;
        end_of_test;
    end
    // Main sequence
    initial begin
        cyc(20);
        srst <= 1'h0;
        rd(3'h0, 8'h04);
        rd(3'h1, 8'h07);
        rd(3'h2, 8'h38);
        rd(3'h7, 8'h00);
        cts_on <= 1'h1;
        cyc(6);
        chk({7'h0, ext_status_pending}, 8'h01);
        cts_on <= 1'h0;
        cyc(6);
        rd(3'h0, st0(1'h1, 1'h0, 1'h1));
        wr(3'h2, 8'h00);
        wr(3'h4, 8'h02);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            cts_on <= seed[0];
            car_on <= seed[1];
            cyc(6);
            rd(3'h0, st0(seed[0], seed[1], 1'h1));
        end
        cts_on <= 1'h0;
        car_on <= 1'h0;
        wr(3'h2, 8'h02);
        brg_zero <= 1'h1;
        rd(3'h0, 8'h06);
        brg_zero <= 1'h0;
        tx_load <= 1'h1;
        cyc(1);
        tx_load <= 1'h0;
        rd(3'h0, 8'h00);
        tx_taken <= 1'h1;
        cyc(1);
        tx_taken <= 1'h0;
        crc_sending <= 1'h1;
        rd(3'h0, 8'h00);
        crc_sending <= 1'h0;
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            q[i] = seed;
            push(seed, ^seed, 1'h0);
        end
        rd(3'h0, 8'h05);
        for (int i = 0; i < 3; i++)
            rd(3'h5, q[i]);
        rd(3'h0, 8'h04);
        wr(3'h3, 8'h50);
        push(seed, ~^seed, 1'h0);
        rd(3'h1, 8'h17);
        rd(3'h5, seed);
        rd(3'h1, 8'h17);
        chk({7'h0, special_rx_cond}, 8'h01);
        wr(3'h4, 8'h04);
        rd(3'h1, 8'h07);
        chk({7'h0, special_rx_cond}, 8'h00);
        repeat (4) push(8'h5A, ^8'h5A, 1'h0);
        rd(3'h5, 8'h5A);
        rd(3'h5, 8'h5A);
        rd(3'h1, 8'h27);
        rd(3'h5, 8'h5A);
        rd(3'h1, 8'h27);
        chk({7'h0, special_rx_cond}, 8'h01);
        wr(3'h4, 8'h04);
        rd(3'h1, 8'h07);
        push(seed, ^seed, 1'h1);
        clk_run <= 1'h1;
        rd(3'h1, 8'h47);
        chk({7'h0, start_bit_blank}, 8'h01);
        cyc(90);
        chk({7'h0, start_bit_blank}, 8'h00);
        clk_run <= 1'h0;
        rd(3'h5, seed);
        wr(3'h3, 8'h01);
        wr(3'h4, 8'h01);
        rd(3'h0, 8'h14);
        chk({7'h0, sync_pin_oe}, 8'h01);
        sync_pattern_det <= 1'h1;
        cyc(1);
        sync_pattern_det <= 1'h0;
        #1 chk({7'h0, sync_pin_out_n}, 8'h00);
        char_sync_done <= 1'h1;
        cyc(1);
        char_sync_done <= 1'h0;
        rd(3'h0, 8'h04);
        end_of_test;
    end
endmodule // test_scs_status_regs
